// ### dv/host_model.sv
// host model driving the init pin and the serial lines
`timescale 1ns/10ps
module host_model #(
  // panel supply settle or discharge wait; default is 100 ms of 50 ns cycles
  parameter integer SETTLE_CYCLES = 2000000
) (
  // clock
  input wire sys_clk,
  // init pin and serial lines
  output reg chip_init_n,
  output reg ser_clk,
  output reg ser_cs_n,
  output reg ser_data,
  output reg ser_dc
);
  // idle lines, init held low from power up
  initial begin
    chip_init_n = 1'b0;
    ser_clk = 1'b0;
    ser_cs_n = 1'b1;
    ser_data = 1'b0;
    ser_dc = 1'b0;
  end
  // drive the init pin
  task set_init(input v);
    chip_init_n <= v;
  endtask
  // wait while the panel supply settles or discharges
  task settle;
    repeat (SETTLE_CYCLES) @(posedge sys_clk);
  endtask
  // init low for n edges, released before any command
  task init_pulse(input integer n);
    set_init(1'b0);
    repeat (n) @(posedge sys_clk);
    set_init(1'b1);
    @(posedge sys_clk);
  endtask
  // n bits msb first, each level held three edges; clock still outside frames
  task send_bits(input [7:0] b, input integer n, input dc);
    integer j;
    ser_cs_n <= 1'b0;
    ser_dc <= dc;
    for (j = 7; j > 7 - n; j = j - 1) begin
      ser_data <= b[j];
      repeat (3) @(posedge sys_clk);
      ser_clk <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ser_clk <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask
  // deselect, released data line shows the inverse
  task release_cs;
    ser_cs_n <= 1'b1;
    ser_data <= ~ser_data;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule // host_model

// ### dv/oled_init_asserts.sv
// concurrent checks on init defaults and bus answer of the display init block
`timescale 1ns/10ps
`include "oled_init_defines.vh"
module oled_init_asserts #(
  parameter [7:0] COL_COUNT = 8'ha0
) (
  // clock and reset
  input wire       sys_clk,
  input wire       resetn,
  // init pin and bus handshake
  input wire       chip_init_n,
  input wire       avs_read,
  input wire       avs_write,
  input wire       avs_waitrequest,
  // panel settings
  input wire       display_on_q,
  input wire [1:0] display_mode_q,
  input wire [7:0] row_multiplex_ratio_q,
  input wire [7:0] start_line_q,
  input wire [7:0] display_offset_q,
  input wire       first_segment_output_remap_q,
  input wire       first_common_output_remap_q,
  input wire [7:0] column_addr_q,
  input wire [3:0] master_contrast_q,
  input wire [7:0] contrast_a_q,
  input wire [7:0] contrast_b_q,
  input wire [7:0] contrast_c_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // init pin low once, and held over two edges
  sequence s_init;
    !chip_init_n;
  endsequence
  sequence s_init_held;
    !chip_init_n [*2];
  endsequence
  // request taken while the slave is idle
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  a_init_off: assert property (
    s_init_held |-> !display_on_q) else $error("display on during init");
  a_mux_default: assert property (
    s_init |=> row_multiplex_ratio_q == `DEF_MUX) else $error("mux not 64");
  a_start_offset: assert property (
    s_init |=> start_line_q == `DEF_START && display_offset_q == `DEF_OFFSET)
    else $error("start or offset not 0");
  a_map_plain: assert property (
    s_init |=> !first_segment_output_remap_q && !first_common_output_remap_q)
    else $error("remap set after init");
  a_column_clear: assert property (
    s_init |=> column_addr_q == `DEF_COLUMN) else $error("column not 0");
  a_master_default: assert property (
    s_init |=> master_contrast_q == `DEF_MASTER) else $error("master not 0f");
  a_colour_default: assert property (
    s_init |=> contrast_a_q == `DEF_CON && contrast_b_q == `DEF_CON
      && contrast_c_q == `DEF_CON) else $error("colour contrast not 80");
  a_mode_normal: assert property (
    s_init |=> display_mode_q == `MODE_NORMAL) else $error("mode not normal");
  a_bus_answer: assert property (
    s_taken |=> !avs_waitrequest) else $error("no answer one cycle after request");
  a_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer longer than a cycle");
endmodule // oled_init_asserts

// ### dv/testbench.sv
// bench for the display init block with host model and avalon master
`timescale 1ns/10ps
`include "oled_init_defines.vh"
module testbench;
  reg         sys_clk;
  reg         resetn;
  reg  [5:0]  avs_address;
  reg         avs_read;
  reg         avs_write;
  reg  [31:0] avs_writedata;
  reg  [3:0]  avs_byteenable;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  wire        chip_init_n;
  wire        ser_clk;
  wire        ser_cs_n;
  wire        ser_data;
  wire        ser_dc;
  wire        init_active;
  wire [64:0] outs;
  reg  [31:0] seed;
  reg  [31:0] q;
  reg  [7:0]  b;
  reg  [31:0] wd;
  integer     i;
  integer     k;
  integer     n_mismatch;
  integer     samples_checked;
  localparam [64:0] DEF_OUTS = {`DEF_DISP_ON, `DEF_MODE, `DEF_MUX, `DEF_START, `DEF_OFFSET,
    `DEF_SEG_REMAP, `DEF_COM_REMAP, `DEF_COLUMN, `DEF_MASTER, `DEF_CON, `DEF_CON, `DEF_CON};
  // design, host model
  oled_init_regs dut (.sys_clk(sys_clk), .resetn(resetn), .chip_init_n(chip_init_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ser_clk(ser_clk),
    .ser_cs_n(ser_cs_n), .ser_data(ser_data), .ser_dc(ser_dc), .display_on_q(outs[64]),
    .display_mode_q(outs[63:62]), .row_multiplex_ratio_q(outs[61:54]),
    .start_line_q(outs[53:46]), .display_offset_q(outs[45:38]),
    .first_segment_output_remap_q(outs[37]), .first_common_output_remap_q(outs[36]),
    .column_addr_q(outs[35:28]), .master_contrast_q(outs[27:24]),
    .contrast_a_q(outs[23:16]), .contrast_b_q(outs[15:8]), .contrast_c_q(outs[7:0]),
    .init_active_q(init_active));
  // settle wait shortened to keep the run short
  host_model #(.SETTLE_CYCLES(20)) host (.sys_clk(sys_clk), .chip_init_n(chip_init_n),
    .ser_clk(ser_clk), .ser_cs_n(ser_cs_n), .ser_data(ser_data), .ser_dc(ser_dc));
  // clock
  always #25 sys_clk = ~sys_clk;
  // compare and count
  task chk(input [64:0] got, input [64:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one transfer, held until waitrequest is sampled low
  task bus(input [5:0] a, input wr, input [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  // init default of each register
  function [31:0] def_of(input [5:0] a);
    case (a)
      `OFS_MUX: def_of = {24'h0, `DEF_MUX};
      `OFS_MASTER: def_of = {28'h0, `DEF_MASTER};
      `OFS_CON_A, `OFS_CON_B, `OFS_CON_C: def_of = {24'h0, `DEF_CON};
      default: def_of = 32'h0;
    endcase
  endfunction
  // bits each register from mux to colour c keeps from a write
  function [31:0] mask_of(input [5:0] a);
    mask_of = (a == `OFS_MASTER) ? 32'h0000000f : 32'h000000ff;
  endfunction
  // ports and registers against the defaults
  task check_defaults;
    chk(outs, DEF_OUTS);
    for (i = 0; i < 9; i = i + 1) begin
      bus({i[3:0], 2'b00}, 1'b0, 32'h0);
      chk({33'h0, q}, {33'h0, def_of({i[3:0], 2'b00})});
    end
  endtask
  // verdict
  task final_report;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(50 * 6000);
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  // main sequence
  initial begin
    seed = 32'h3c4a;
    n_mismatch = 0;
    samples_checked = 0;
    sys_clk = 1'b0;
    resetn = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    host.init_pulse(4);
    check_defaults;
    // power up: display off, panel supply settles, display on below
    bus(`OFS_CTRL, 1'b1, 32'h0);
    host.settle;
    for (k = 0; k < 2; k = k + 1) begin
      // every mode with display on and random remaps
      for (i = 0; i < 4; i = i + 1) begin
        wd = ($random(seed) & 32'h18) | {29'h0, i[1:0], 1'b1};
        bus(`OFS_CTRL, 1'b1, wd);
        chk({60'h0, outs[64:62], outs[37:36]}, {60'h0, wd[0], wd[2:1], wd[3], wd[4]});
      end
      // random settings read back, then a write with lane 0 off is ignored
      for (i = 1; i < 9; i = i + 1) begin
        wd = $random(seed);
        bus({i[3:0], 2'b00}, 1'b1, wd);
        bus({i[3:0], 2'b00}, 1'b0, 32'h0);
        chk({33'h0, q}, {33'h0, wd & mask_of({i[3:0], 2'b00})});
      end
      avs_byteenable <= 4'he;
      bus(`OFS_CON_C, 1'b1, ~wd);
      avs_byteenable <= 4'hf;
      bus(`OFS_CON_C, 1'b0, 32'h0);
      chk({33'h0, q}, {57'h0, wd[7:0]});
      // init mid-run by the pin with an ignored write, then by reset
      if (k == 0) begin
        host.set_init(1'b0);
        bus(`OFS_MUX, 1'b1, 32'h0000_0011);
        chk({64'h0, init_active}, {64'h0, 1'b1});
      end else begin
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
      end
      check_defaults;
      host.set_init(1'b1);
      @(posedge sys_clk);
    end
    // partial serial bits dropped by init, then a whole data byte
    wd = $random(seed);
    b = wd[7:0];
    host.send_bits(8'h5a, 5, 1'b1);
    host.init_pulse(3);
    host.send_bits(b, 8, 1'b1);
    host.release_cs;
    bus(`OFS_STATUS, 1'b0, 32'h0);
    chk({33'h0, q}, {49'h0, b, 8'h06});
    chk({57'h0, outs[35:28]}, {57'h0, 8'h01});
    // the status read cleared the valid flag
    bus(`OFS_STATUS, 1'b0, 32'h0);
    chk({33'h0, q}, {49'h0, b, 8'h04});
    // unmapped address reads zero
    bus(6'h3c, 1'b0, 32'h0);
    chk({33'h0, q}, 65'h0);
    // power down: display off, panel supply off, discharge wait
    bus(`OFS_CTRL, 1'b1, 32'h0);
    chk({64'h0, outs[64]}, 65'h0);
    host.settle;
    final_report;
  end
endmodule // testbench

bind oled_init_regs oled_init_asserts #(.COL_COUNT(COL_COUNT)) u_asserts (
  .sys_clk(sys_clk), .resetn(resetn), .chip_init_n(chip_init_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .display_on_q(display_on_q),
  .display_mode_q(display_mode_q), .row_multiplex_ratio_q(row_multiplex_ratio_q),
  .start_line_q(start_line_q), .display_offset_q(display_offset_q),
  .first_segment_output_remap_q(first_segment_output_remap_q),
  .first_common_output_remap_q(first_common_output_remap_q),
  .column_addr_q(column_addr_q), .master_contrast_q(master_contrast_q),
  .contrast_a_q(contrast_a_q), .contrast_b_q(contrast_b_q), .contrast_c_q(contrast_c_q));

// ### hdl/oled_init_defines.vh
// register offsets, field positions, reset defaults and widths of the display init block
`ifndef OLED_INIT_DEFINES_VH
`define OLED_INIT_DEFINES_VH

// register byte offsets
`define OFS_CTRL        6'h00
`define OFS_MUX         6'h04
`define OFS_START       6'h08
`define OFS_OFFSET      6'h0c
`define OFS_COLUMN      6'h10
`define OFS_MASTER      6'h14
`define OFS_CON_A       6'h18
`define OFS_CON_B       6'h1c
`define OFS_CON_C       6'h20
`define OFS_STATUS      6'h24

// control register fields
`define CTRL_ON_BIT     0
`define CTRL_MODE_LO    1
`define CTRL_MODE_HI    2
`define CTRL_SEG_BIT    3
`define CTRL_COM_BIT    4

// status register fields
`define STAT_INIT_BIT   0
`define STAT_VALID_BIT  1
`define STAT_DC_BIT     2
`define STAT_BYTE_LO    8
`define STAT_BYTE_HI    15

// display modes
`define MODE_NORMAL     2'h0
`define MODE_ALL_ON     2'h1
`define MODE_ALL_OFF    2'h2
`define MODE_INVERSE    2'h3

// defaults forced by initialisation
`define DEF_DISP_ON     1'h0
`define DEF_MUX         8'h40
`define DEF_START       8'h00
`define DEF_OFFSET      8'h00
`define DEF_SEG_REMAP   1'h0
`define DEF_COM_REMAP   1'h0
`define DEF_COLUMN      8'h00
`define DEF_MASTER      4'hf
`define DEF_CON         8'h80
`define DEF_MODE        2'h0

// serial shifter
`define SER_BITS        4'h8
`define SER_LAST_BIT    4'h7
`define SER_CNT_ZERO    4'h0
`define BYTE_ZERO       8'h00

`endif

// ### hdl/oled_init_regs.v
// display driver configuration registers with initialisation defaults and avalon slave
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps

// Contract
// [R01] While chip_init_n is low the block initialises itself and holds the display off.
// [R02] Initialisation sets the row multiplex ratio to 64 lines.
// [R03] Initialisation sets the start line to row 0 and the vertical offset to 0.
// [R04] Initialisation selects unremapped segment and common addressing from address 00h.
// [R05] Initialisation clears the column address counter to zero.
// [R06] Initialisation loads the master contrast with 0fh.
// [R07] Initialisation loads the contrast of colours a, b and c with 80h each.
// [R08] Initialisation drops any partly received bits in the serial shifter.
// [R09] Initialisation selects the normal display mode that shows ram contents.
// [R10] The host powers logic first, sends display off, initialises, clears, then panel power.
// [R11] The host waits 100 ms after panel power before sending display on.
// [R12] The host sends display off, drops panel power, waits 100 ms, then drops logic power.
// [R13] The host should repeat the initialisation when noise spoils the image.
// [R14] The host holds chip_init_n low a while after logic power and releases it before commands.
module oled_init_regs #(
  parameter [7:0] COL_COUNT = 8'ha0
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        resetn,
  // chip initialisation pin
  input  wire        chip_init_n,
  // avalon-mm slave
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // serial pins
  input  wire        ser_clk,
  input  wire        ser_cs_n,
  input  wire        ser_data,
  input  wire        ser_dc,
  // panel driver settings
  output reg         display_on_q,
  output reg  [1:0]  display_mode_q,
  output reg  [7:0]  row_multiplex_ratio_q,
  output reg  [7:0]  start_line_q,
  output reg  [7:0]  display_offset_q,
  output reg         first_segment_output_remap_q,
  output reg         first_common_output_remap_q,
  output reg  [7:0]  column_addr_q,
  output reg  [3:0]  master_contrast_q,
  output reg  [7:0]  contrast_a_q,
  output reg  [7:0]  contrast_b_q,
  output reg  [7:0]  contrast_c_q,
  output reg         init_active_q
);

`include "oled_init_defines.vh"

  localparam [7:0] COL_LAST = COL_COUNT - 8'h01;

  // bus handshake states
  localparam [1:0] BUS_IDLE = 2'h0;
  localparam [1:0] BUS_ACK  = 2'h1;

  reg  [1:0]  bus_state_q;
  reg  [31:0] rd_value_d;
  reg         byte_valid_q;
  reg  [7:0]  rx_byte_q;
  reg         rx_dc_q;
  wire        init_now;
  wire        wr_fire;
  wire        rd_fire;
  wire        wr_lane;
  wire [7:0]  wr_byte;
  wire [7:0]  sh_byte;
  wire        sh_dc;
  wire        sh_strobe;
  wire        data_byte;
  wire        wr_ctrl;
  wire        wr_mux;
  wire        wr_start;
  wire        wr_offset;
  wire        wr_column;
  wire        wr_master;
  wire        wr_con_a;
  wire        wr_con_b;
  wire        wr_con_c;
  wire        rd_status;

  // register decode used by the read mux and every write
  function hit;
    input [5:0] addr;
    input [5:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // initialisation is either reset or the init pin low
  assign init_now  = !resetn || !chip_init_n;       // [R01]
  assign wr_fire   = avs_write && (bus_state_q == BUS_ACK);
  assign rd_fire   = avs_read && (bus_state_q == BUS_IDLE);  // edge that snapshots read data
  assign wr_lane   = wr_fire && avs_byteenable[0] && !init_now;
  assign wr_byte   = avs_writedata[7:0];
  assign data_byte = sh_strobe && sh_dc && !init_now;

  // one strobe per register, decoded once
  assign wr_ctrl   = wr_lane && hit(avs_address, `OFS_CTRL);
  assign wr_mux    = wr_lane && hit(avs_address, `OFS_MUX);
  assign wr_start  = wr_lane && hit(avs_address, `OFS_START);
  assign wr_offset = wr_lane && hit(avs_address, `OFS_OFFSET);
  assign wr_column = wr_lane && hit(avs_address, `OFS_COLUMN);
  assign wr_master = wr_lane && hit(avs_address, `OFS_MASTER);
  assign wr_con_a  = wr_lane && hit(avs_address, `OFS_CON_A);
  assign wr_con_b  = wr_lane && hit(avs_address, `OFS_CON_B);
  assign wr_con_c  = wr_lane && hit(avs_address, `OFS_CON_C);
  assign rd_status = rd_fire && hit(avs_address, `OFS_STATUS);

  // serial shifter, cleared while initialising
  ser_shift u_ser_shift (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .clear    (!chip_init_n),
    .ser_clk  (ser_clk),
    .ser_cs_n (ser_cs_n),
    .ser_data (ser_data),
    .ser_dc   (ser_dc),
    .byte_q   (sh_byte),
    .dc_q     (sh_dc),
    .strobe_q (sh_strobe)
  );

  // read mux, unmapped offsets read zero
  always @* begin
    rd_value_d = 32'h00000000;
    if (hit(avs_address, `OFS_CTRL)) begin
      rd_value_d[`CTRL_ON_BIT]                  = display_on_q;
      rd_value_d[`CTRL_MODE_HI:`CTRL_MODE_LO]   = display_mode_q;
      rd_value_d[`CTRL_SEG_BIT]                 = first_segment_output_remap_q;
      rd_value_d[`CTRL_COM_BIT]                 = first_common_output_remap_q;
    end else if (hit(avs_address, `OFS_MUX)) begin
      rd_value_d[7:0] = row_multiplex_ratio_q;
    end else if (hit(avs_address, `OFS_START)) begin
      rd_value_d[7:0] = start_line_q;
    end else if (hit(avs_address, `OFS_OFFSET)) begin
      rd_value_d[7:0] = display_offset_q;
    end else if (hit(avs_address, `OFS_COLUMN)) begin
      rd_value_d[7:0] = column_addr_q;
    end else if (hit(avs_address, `OFS_MASTER)) begin
      rd_value_d[3:0] = master_contrast_q;
    end else if (hit(avs_address, `OFS_CON_A)) begin
      rd_value_d[7:0] = contrast_a_q;
    end else if (hit(avs_address, `OFS_CON_B)) begin
      rd_value_d[7:0] = contrast_b_q;
    end else if (hit(avs_address, `OFS_CON_C)) begin
      rd_value_d[7:0] = contrast_c_q;
    end else if (hit(avs_address, `OFS_STATUS)) begin
      rd_value_d[`STAT_INIT_BIT]                = init_active_q;
      rd_value_d[`STAT_VALID_BIT]               = byte_valid_q;
      rd_value_d[`STAT_DC_BIT]                  = rx_dc_q;
      rd_value_d[`STAT_BYTE_HI:`STAT_BYTE_LO]   = rx_byte_q;
    end
  end

  // waitrequest handshake: one wait cycle, then one answer cycle
  always @(posedge sys_clk) begin
    if (!resetn) begin
      bus_state_q     <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      case (bus_state_q)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_q     <= BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_value_d : 32'h00000000;
          end
        end
        BUS_ACK: begin
          bus_state_q     <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state_q     <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // init status follows the pin, visible to software
  always @(posedge sys_clk) begin
    if (!resetn) begin
      init_active_q <= 1'b1;
    end else begin
      init_active_q <= !chip_init_n;
    end
  end

  // display control, held at defaults while initialising
  always @(posedge sys_clk) begin
    if (init_now) begin
      display_on_q                 <= `DEF_DISP_ON;     // [R01]
      display_mode_q               <= `DEF_MODE;        // [R09]
      first_segment_output_remap_q <= `DEF_SEG_REMAP;   // [R04]
      first_common_output_remap_q  <= `DEF_COM_REMAP;   // [R04]
    end else if (wr_ctrl) begin
      display_on_q                 <= wr_byte[`CTRL_ON_BIT];
      display_mode_q               <= wr_byte[`CTRL_MODE_HI:`CTRL_MODE_LO];
      first_segment_output_remap_q <= wr_byte[`CTRL_SEG_BIT];
      first_common_output_remap_q  <= wr_byte[`CTRL_COM_BIT];
    end
  end

  // multiplex ratio
  always @(posedge sys_clk) begin
    if (init_now) begin
      row_multiplex_ratio_q <= `DEF_MUX;                // [R02]
    end else if (wr_mux) begin
      row_multiplex_ratio_q <= wr_byte;
    end
  end

  // display start line
  always @(posedge sys_clk) begin
    if (init_now) begin
      start_line_q <= `DEF_START;                       // [R03]
    end else if (wr_start) begin
      start_line_q <= wr_byte;
    end
  end

  // vertical display offset
  always @(posedge sys_clk) begin
    if (init_now) begin
      display_offset_q <= `DEF_OFFSET;                  // [R03]
    end else if (wr_offset) begin
      display_offset_q <= wr_byte;
    end
  end

  // master contrast, low nibble of the byte
  always @(posedge sys_clk) begin
    if (init_now) begin
      master_contrast_q <= `DEF_MASTER;                 // [R06]
    end else if (wr_master) begin
      master_contrast_q <= wr_byte[3:0];
    end
  end

  // colour a contrast
  always @(posedge sys_clk) begin
    if (init_now) begin
      contrast_a_q <= `DEF_CON;                         // [R07]
    end else if (wr_con_a) begin
      contrast_a_q <= wr_byte;
    end
  end

  // colour b contrast
  always @(posedge sys_clk) begin
    if (init_now) begin
      contrast_b_q <= `DEF_CON;                         // [R07]
    end else if (wr_con_b) begin
      contrast_b_q <= wr_byte;
    end
  end

  // colour c contrast
  always @(posedge sys_clk) begin
    if (init_now) begin
      contrast_c_q <= `DEF_CON;                         // [R07]
    end else if (wr_con_c) begin
      contrast_c_q <= wr_byte;
    end
  end

  // column counter: software load, advance per serial data byte
  always @(posedge sys_clk) begin
    if (init_now) begin
      column_addr_q <= `DEF_COLUMN;                     // [R05]
    end else if (wr_column) begin
      column_addr_q <= wr_byte;
    end else if (data_byte) begin
      if (column_addr_q >= COL_LAST) begin
        column_addr_q <= `DEF_COLUMN;
      end else begin
        column_addr_q <= column_addr_q + 8'h01;
      end
    end
  end

  // last received serial byte; valid flag cleared on the edge the status is snapshot, a new byte wins
  always @(posedge sys_clk) begin
    if (init_now) begin
      byte_valid_q <= 1'b0;                             // [R08]
      rx_byte_q    <= `BYTE_ZERO;
      rx_dc_q      <= 1'b0;
    end else if (sh_strobe) begin
      byte_valid_q <= 1'b1;
      rx_byte_q    <= sh_byte;
      rx_dc_q      <= sh_dc;
    end else if (rd_status) begin
      byte_valid_q <= 1'b0;
    end
  end

endmodule // oled_init_regs

// ### hdl/ser_shift.v
// serial command/data shifter, one byte per eight rising serial clock edges
`timescale 1ns/10ps

module ser_shift (
  // clock and reset
  input  wire       sys_clk,
  input  wire       resetn,
  // clear of partial bits
  input  wire       clear,
  // serial pins
  input  wire       ser_clk,
  input  wire       ser_cs_n,
  input  wire       ser_data,
  input  wire       ser_dc,
  // received byte
  output reg  [7:0] byte_q,
  output reg        dc_q,
  output reg        strobe_q
);

`include "oled_init_defines.vh"

  reg  [7:0] shift_q;
  reg  [3:0] count_q;
  reg        clk_prev_q;
  wire       rise;

  // serial clock edge, pins already synchronous
  assign rise = ser_clk && !clk_prev_q && !ser_cs_n;

  // shift msb first, drop partial bits on clear or deselect
  always @(posedge sys_clk) begin
    if (!resetn || clear) begin
      shift_q    <= `BYTE_ZERO;       // [R08]
      count_q    <= `SER_CNT_ZERO;    // [R08]
      clk_prev_q <= 1'b0;
      byte_q     <= `BYTE_ZERO;
      dc_q       <= 1'b0;
      strobe_q   <= 1'b0;
    end else begin
      clk_prev_q <= ser_clk;
      strobe_q   <= 1'b0;
      if (ser_cs_n) begin
        count_q <= `SER_CNT_ZERO;
      end else if (rise) begin
        shift_q <= {shift_q[6:0], ser_data};
        if (count_q == `SER_LAST_BIT) begin
          count_q  <= `SER_CNT_ZERO;
          byte_q   <= {shift_q[6:0], ser_data};
          dc_q     <= ser_dc;
          strobe_q <= 1'b1;
        end else begin
          count_q <= count_q + 4'h1;
        end
      end
    end
  end

endmodule // ser_shift
